// *** rtl/trail_termination_monitor.v ***
/*
 * Trail termination and adaptation for a byte-wide framed path:
 * source inserts overhead, scrambles and justifies; sink aligns,
 * descrambles, checks overhead, replaces failed data and grades seconds.
 * Assumes the client byte stream and elastic store flags are on core_clk_i,
 * while the received line byte comes from outside and is synchronised.
 */
// Functional notes
// - source puts the provisioned access point identifier in the trace byte.
// - sink compares received trace byte with expected one to catch misconnection.
// - source computes parity over each frame and inserts it next frame.
// - sink returns its parity violation count to the far source in status byte.
// - on a frame, pointer, all-ones, trace or label defect the sink outputs all-ones instead of data.
// - on a frame, pointer, all-ones, trace or label defect the return status byte carries the remote defect bit.
// - every detected defect is reported on its own output.
// - near-end block errors are counted per second.
// - far-end block errors from received remote error counts are counted per second.
// - a second with signal fail is flagged as a near-end defect second.
// - a second with received remote defect is flagged far-end defect second.
// - errored, severely errored and unavailable seconds are derived and reported.
// - frame found by pattern search, pointer checked; loss raised after set period.
// - alignment loss with all-ones input also raises the all-ones defect.
// - elastic store near overflow: justification byte carries data.
// - elastic store near underflow: first data position left unwritten.
// - source inserts payload label; sink checks it against expected label.
// - connection change sends new data flag only when generation follows switch.
// - with time switching the pointer generator sits before the matrix.
// - source scrambles frame contents; sink descrambles them.
`include "ttm_regs.vh"

module trail_termination_monitor #(
    parameter integer FRAME_LEN   = 16,
    parameter integer TIME_SWITCH = 0,
    parameter integer TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
    input  wire        core_clk_i,
    input  wire        rstn_i,
    input  wire [7:0]  tx_data_i,
    input  wire        store_near_full_i,
    input  wire        store_near_empty_i,
    input  wire        conn_change_i,
    input  wire [7:0]  access_point_i,
    input  wire [7:0]  payload_label_i,
    input  wire [7:0]  expected_trace_i,
    input  wire [7:0]  expected_label_i,
    input  wire [7:0]  line_rx_i,
    output reg  [7:0]  line_tx_o,
    output reg         tx_take_o,
    output reg  [7:0]  rx_data_o,
    output reg         rx_valid_o,
    output reg         loss_of_frame_o,
    output reg         loss_of_pointer_o,
    output reg         alarm_indication_signal_o,
    output reg         trace_mismatch_o,
    output reg         label_mismatch_o,
    output reg         remote_defect_indication_o,
    output wire [15:0] near_blocks_o,
    output wire        near_defect_sec_o,
    output wire        near_errored_second_o,
    output wire        near_severely_errored_second_o,
    output wire        near_unavailable_second_o,
    output wire [15:0] far_blocks_o,
    output wire        far_defect_sec_o,
    output wire        far_errored_second_o,
    output wire        far_severely_errored_second_o,
    output wire        far_unavailable_second_o
);
    localparam [2:0] ST_HUNT    = 3'b001;
    localparam [2:0] ST_PRESYNC = 3'b010;
    localparam [2:0] ST_SYNC    = 3'b100;

    // number of differing bits in a parity byte
    function [3:0] bit_count;
        input [7:0] v;
        integer i;
        begin
            bit_count = 4'h0;
            for (i = 0; i < 8; i = i + 1)
                bit_count = bit_count + {3'b000, v[i]};
        end
    endfunction

    // ---------------- source direction ----------------
    reg  [7:0] tx_pos;
    reg  [7:0] tx_raw;
    reg        tx_take;
    reg        jpos;
    reg        jneg;
    reg        ndf_pend;
    reg  [7:0] tx_bip_acc;
    reg  [7:0] tx_bip;
    reg  [3:0] rei_hold;
    reg        defect;
    wire [7:0] tx_scr;
    wire       tx_last = (tx_pos == FRAME_LEN - 1);

    // overhead and payload multiplexer for the current position
    always @* begin
        tx_take = 1'b0;
        case (tx_pos)
            `POS_PAT1:  tx_raw = `PAT1_VAL;
            `POS_PAT2:  tx_raw = `PAT2_VAL;
            `POS_TRACE: tx_raw = access_point_i;
            `POS_EDC:   tx_raw = tx_bip;
            `POS_STAT:  tx_raw = {rei_hold, 1'b0, jneg, jpos, defect};
            `POS_LABEL: tx_raw = payload_label_i;
            `POS_PTR:   tx_raw = {ndf_pend, 7'h00};
            `POS_JUST: begin
                tx_raw  = jpos ? tx_data_i : 8'h00;
                tx_take = jpos;
            end
            default: begin
                tx_raw  = (tx_pos == `POS_FIRST && jneg) ? 8'h00 : tx_data_i;
                tx_take = !(tx_pos == `POS_FIRST && jneg);
            end
        endcase
    end

    // everything past the alignment pattern is scrambled
    byte_scrambler u_tx_scr (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .restart_i  (tx_pos == `POS_PAT2),
        .advance_i  (tx_pos >= `POS_TRACE),
        .data_i     (tx_raw),
        .data_o     (tx_scr)
    );

    // source frame counter, justification decision and parity
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            tx_pos     <= 8'h00;
            jpos       <= 1'b0;
            jneg       <= 1'b0;
            ndf_pend   <= 1'b0;
            tx_bip_acc <= 8'h00;
            tx_bip     <= 8'h00;
            line_tx_o  <= 8'h00;
            tx_take_o  <= 1'b0;
        end else begin
            tx_pos    <= tx_last ? 8'h00 : tx_pos + 8'h01;
            line_tx_o <= (tx_pos >= `POS_TRACE) ? tx_scr : tx_raw;
            tx_take_o <= tx_take;
            if (tx_pos == `POS_PAT1) begin
                jpos <= store_near_full_i;
                jneg <= store_near_empty_i && !store_near_full_i;
            end
            // parity over the transmitted bytes, inserted in the next frame;
            // line_tx_o lags tx_pos by one, so the frame closes at position 0
            if (tx_pos == 8'h00) begin
                tx_bip     <= tx_bip_acc ^ line_tx_o;
                tx_bip_acc <= 8'h00;
            end else begin
                tx_bip_acc <= tx_bip_acc ^ line_tx_o;
            end
            // new data flag only when the generator follows the switch
            if (conn_change_i && TIME_SWITCH == 0)
                ndf_pend <= 1'b1;
            else if (tx_pos == `POS_PTR)
                ndf_pend <= 1'b0;
        end
    end

    // ---------------- sink direction ----------------
    reg  [7:0] rx_s1;
    reg  [7:0] rx_s2;
    reg  [7:0] rx_prev;
    reg  [7:0] rx_pos;
    reg  [2:0] state;
    reg  [2:0] bad_cnt;
    reg  [3:0] lop_cnt;
    reg  [7:0] ones_cnt;
    reg  [7:0] rx_bip_acc;
    reg  [7:0] rx_bip;
    reg        bip_ok;
    reg        rx_jpos;
    reg        rx_jneg;
    reg        near_err;
    reg        far_err;
    wire [7:0] rx_desc;
    wire       rx_last  = (rx_pos == FRAME_LEN - 1);
    wire       in_sync  = (state == ST_SYNC);
    wire       pat_ok   = (rx_prev == `PAT1_VAL) && (rx_s2 == `PAT2_VAL);
    wire [3:0] bip_errs = bit_count(rx_desc ^ rx_bip);

    // line byte arrives from outside the clock domain
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rx_s1   <= 8'h00;
            rx_s2   <= 8'h00;
            rx_prev <= 8'h00;
        end else begin
            rx_s1   <= line_rx_i;
            rx_s2   <= rx_s1;
            rx_prev <= rx_s2;
        end
    end

    byte_scrambler u_rx_scr (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .restart_i  (rx_pos == `POS_PAT2),
        .advance_i  (rx_pos >= `POS_TRACE),
        .data_i     (rx_s2),
        .data_o     (rx_desc)
    );

    // frame alignment: hunt for pattern, confirm once, drop after bad run
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state           <= ST_HUNT;
            rx_pos          <= 8'h00;
            bad_cnt         <= 3'h0;
            loss_of_frame_o <= 1'b1;
        end else begin
            rx_pos <= rx_last ? 8'h00 : rx_pos + 8'h01;
            case (state)
                ST_HUNT: begin
                    if (pat_ok) begin
                        state  <= ST_PRESYNC;
                        rx_pos <= 8'h02;
                    end
                end
                ST_PRESYNC: begin
                    if (rx_pos == `POS_PAT2) begin
                        state   <= pat_ok ? ST_SYNC : ST_HUNT;
                        bad_cnt <= 3'h0;
                        if (pat_ok)
                            loss_of_frame_o <= 1'b0;
                    end
                end
                ST_SYNC: begin
                    if (rx_pos == `POS_PAT2) begin
                        if (pat_ok) begin
                            bad_cnt <= 3'h0;
                        end else if (bad_cnt == `LOF_FRAMES - 1) begin
                            state           <= ST_HUNT;
                            loss_of_frame_o <= 1'b1;
                        end else begin
                            bad_cnt <= bad_cnt + 3'h1;
                        end
                    end
                end
                default: state <= ST_HUNT;
            endcase
        end
    end

    // overhead checks on the descrambled bytes
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ones_cnt                   <= 8'h00;
            alarm_indication_signal_o  <= 1'b0;
            lop_cnt                    <= 4'h0;
            loss_of_pointer_o          <= 1'b0;
            trace_mismatch_o           <= 1'b0;
            label_mismatch_o           <= 1'b0;
            remote_defect_indication_o <= 1'b0;
            rx_bip_acc                 <= 8'h00;
            rx_bip                     <= 8'h00;
            bip_ok                     <= 1'b0;
            rei_hold                   <= 4'h0;
            rx_jpos                    <= 1'b0;
            rx_jneg                    <= 1'b0;
            near_err                   <= 1'b0;
            far_err                    <= 1'b0;
        end else begin
            near_err <= 1'b0;
            far_err  <= 1'b0;
            // run of all-ones bytes, a frame long, while alignment is lost
            if (rx_s2 != `ALL_ONES)
                ones_cnt <= 8'h00;
            else if (ones_cnt != FRAME_LEN)
                ones_cnt <= ones_cnt + 8'h01;
            alarm_indication_signal_o <= loss_of_frame_o && (ones_cnt == FRAME_LEN);
            // parity of the received frame, checked against next frame
            if (rx_last) begin
                rx_bip     <= rx_bip_acc ^ rx_s2;
                rx_bip_acc <= 8'h00;
                bip_ok     <= in_sync;
            end else begin
                rx_bip_acc <= rx_bip_acc ^ rx_s2;
            end
            if (!in_sync) begin
                bip_ok                     <= 1'b0;
                remote_defect_indication_o <= 1'b0;
            end else begin
                case (rx_pos)
                    `POS_TRACE: trace_mismatch_o <= (rx_desc != expected_trace_i);
                    `POS_LABEL: label_mismatch_o <= (rx_desc != expected_label_i);
                    `POS_EDC: begin
                        rei_hold <= bip_ok ? bip_errs : 4'h0;
                        near_err <= bip_ok && (bip_errs != 4'h0);
                    end
                    `POS_STAT: begin
                        far_err <= (rx_desc[`STAT_REI_HI:`STAT_REI_LO] != 4'h0);
                        remote_defect_indication_o <= rx_desc[`STAT_RDI];
                        rx_jpos <= rx_desc[`STAT_JPOS];
                        rx_jneg <= rx_desc[`STAT_JNEG];
                    end
                    `POS_PTR: begin
                        // offset must land inside the payload area
                        if (rx_desc[6:0] < FRAME_LEN - `POS_FIRST) begin
                            lop_cnt           <= 4'h0;
                            loss_of_pointer_o <= 1'b0;
                        end else if (lop_cnt == `LOP_FRAMES - 1) begin
                            loss_of_pointer_o <= 1'b1;
                        end else begin
                            lop_cnt <= lop_cnt + 4'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // signal fail and data replacement toward the client
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            defect     <= 1'b1;
            rx_data_o  <= `ALL_ONES;
            rx_valid_o <= 1'b0;
        end else begin
            defect <= loss_of_frame_o | loss_of_pointer_o | alarm_indication_signal_o |
                      trace_mismatch_o | label_mismatch_o;
            rx_data_o <= defect ? `ALL_ONES : rx_desc;
            rx_valid_o <= (rx_pos == `POS_JUST) ? rx_jpos :
                          (rx_pos >= `POS_FIRST) && !(rx_pos == `POS_FIRST && rx_jneg);
        end
    end

    // ---------------- one-second grading ----------------
    reg [25:0] tick_cnt;
    reg        tick;

    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            tick_cnt <= 26'h0000000;
            tick     <= 1'b0;
        end else begin
            tick     <= (tick_cnt == TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 26'h0000000 : tick_cnt + 26'h0000001;
        end
    end

    perf_second u_near (
        .core_clk_i   (core_clk_i),
        .rstn_i       (rstn_i),
        .tick_i       (tick),
        .err_i        (near_err),
        .defect_i     (defect),
        .count_o      (near_blocks_o),
        .defect_sec_o (near_defect_sec_o),
        .es_o         (near_errored_second_o),
        .ses_o        (near_severely_errored_second_o),
        .uas_o        (near_unavailable_second_o)
    );

    perf_second u_far (
        .core_clk_i   (core_clk_i),
        .rstn_i       (rstn_i),
        .tick_i       (tick),
        .err_i        (far_err),
        .defect_i     (remote_defect_indication_o),
        .count_o      (far_blocks_o),
        .defect_sec_o (far_defect_sec_o),
        .es_o         (far_errored_second_o),
        .ses_o        (far_severely_errored_second_o),
        .uas_o        (far_unavailable_second_o)
    );
endmodule // trail_termination_monitor

// *** inc/ttm_regs.vh ***
/*
 * Constants for the trail termination monitor: frame byte positions,
 * overhead field layouts, alignment values and timing counts.
 * Assumes a byte-wide frame with all overhead at fixed positions.
 */
`ifndef TTM_REGS_VH
`define TTM_REGS_VH

// byte positions inside one frame
`define POS_PAT1   0
`define POS_PAT2   1
`define POS_TRACE  2
`define POS_EDC    3
`define POS_STAT   4
`define POS_LABEL  5
`define POS_PTR    6
`define POS_JUST   7
`define POS_FIRST  8

// frame alignment pattern bytes and the all-ones byte value
`define PAT1_VAL   8'hF6
`define PAT2_VAL   8'h28
`define ALL_ONES   8'hFF

// status byte fields
`define STAT_RDI   0
`define STAT_JPOS  1
`define STAT_JNEG  2
`define STAT_REI_HI 7
`define STAT_REI_LO 4

// pointer byte fields
`define PTR_NDF    7

// scrambler seed at the start of each frame
`define SCR_SEED   7'h7F

// supervision periods
`define LOF_FRAMES 4
`define LOP_FRAMES 8
`define UAS_SECS   10
`define SES_BLOCKS 30

// one-second tick: time in ms and clock rate in kHz
`define TICK_MS    1000
`define CLK_KHZ    50000

`endif

// *** rtl/byte_scrambler.v ***
/*
 * Frame-synchronous byte scrambler, polynomial x^7 + x^6 + 1.
 * Assumes the caller restarts it once per frame and advances it once
 * for each byte that is scrambled; the same module descrambles.
 */
`include "ttm_regs.vh"

module byte_scrambler (
    input  wire       core_clk_i,
    input  wire       rstn_i,
    input  wire       restart_i,
    input  wire       advance_i,
    input  wire [7:0] data_i,
    output wire [7:0] data_o
);
    reg [6:0] state;
    reg [6:0] walk;
    reg [7:0] keystream;
    integer   k;

    // eight steps of the generator, first bit lands in the msb
    always @* begin
        walk = state;
        keystream = 8'h00;
        for (k = 7; k >= 0; k = k - 1) begin
            keystream[k] = walk[6];
            walk = {walk[5:0], walk[6] ^ walk[5]};
        end
    end

    assign data_o = data_i ^ keystream;

    // generator state: reseeded per frame, stepped per byte
    always @(posedge core_clk_i) begin
        if (!rstn_i || restart_i) begin
            state <= `SCR_SEED;
        end else if (advance_i) begin
            state <= walk;
        end
    end
endmodule // byte_scrambler

// *** rtl/perf_second.v ***
/*
 * Per-second performance collector for one end (near or far).
 * Assumes one block error pulse per block at most and a one-cycle
 * tick that closes each second.
 */
`include "ttm_regs.vh"

module perf_second #(
    parameter integer CW         = 16,
    parameter integer SES_BLOCKS = `SES_BLOCKS,
    parameter integer UAS_SECS   = `UAS_SECS
) (
    input  wire          core_clk_i,
    input  wire          rstn_i,
    input  wire          tick_i,
    input  wire          err_i,
    input  wire          defect_i,
    output reg  [CW-1:0] count_o,
    output reg           defect_sec_o,
    output reg           es_o,
    output reg           ses_o,
    output reg           uas_o
);
    reg  [CW-1:0] cnt;
    reg           dflag;
    reg  [7:0]    run;
    wire          ses_now = (cnt >= SES_BLOCKS) || dflag;

    // running count and defect flag; an event on the tick opens the new second
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt   <= {CW{1'b0}};
            dflag <= 1'b0;
        end else if (tick_i) begin
            cnt   <= err_i ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
            dflag <= defect_i;
        end else begin
            if (err_i && cnt != {CW{1'b1}})
                cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
            if (defect_i)
                dflag <= 1'b1;
        end
    end

    // latch the closed second and grade it
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            count_o      <= {CW{1'b0}};
            defect_sec_o <= 1'b0;
            es_o         <= 1'b0;
            ses_o        <= 1'b0;
            uas_o        <= 1'b0;
            run          <= 8'h00;
        end else if (tick_i) begin
            count_o      <= cnt;
            defect_sec_o <= dflag;
            es_o         <= (cnt != {CW{1'b0}}) || dflag;
            ses_o        <= ses_now;
            // unavailable after a run of severe seconds, back after a run of non-severe ones
            if (ses_now != uas_o) begin
                if (run == UAS_SECS - 1) begin
                    uas_o <= ses_now;
                    run   <= 8'h00;
                end else begin
                    run <= run + 8'h01;
                end
            end else begin
                run <= 8'h00;
            end
        end
    end
endmodule // perf_second

// *** tb/trail_termination_monitor_assertions.sv ***
/* checker for trail_termination_monitor, bound to its ports.
   assumes the frame phase follows from the first pattern byte after reset. */
module ttm_checker #(
    parameter integer FRAME_LEN = 16
) (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        store_near_full_i,
    input wire logic        store_near_empty_i,
    input wire logic [7:0]  line_tx_o,
    input wire logic        tx_take_o,
    input wire logic [7:0]  rx_data_o,
    input wire logic        loss_of_frame_o,
    input wire logic        loss_of_pointer_o,
    input wire logic        alarm_indication_signal_o,
    input wire logic        trace_mismatch_o,
    input wire logic        label_mismatch_o,
    input wire logic [15:0] near_blocks_o,
    input wire logic        near_defect_sec_o,
    input wire logic        near_errored_second_o,
    input wire logic        near_severely_errored_second_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       synced;
    logic [7:0] pos;
    wire        dflt = loss_of_frame_o | loss_of_pointer_o | alarm_indication_signal_o |
                       trace_mismatch_o | label_mismatch_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // frame position of the byte now on the line output
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            synced <= 1'b0;
            pos    <= 8'h00;
        end else if (!synced) begin
            synced <= (line_tx_o == 8'hF6);
            pos    <= 8'h01;
        end else begin
            pos <= (pos == 8'(FRAME_LEN - 1)) ? 8'h00 : pos + 8'h01;
        end
    end
    AST_PAT_FIRST: assert property (
        synced && pos == 8'h00 |-> line_tx_o == 8'hF6) else $error("pattern byte one missing");
    AST_PAT_SECOND: assert property (
        synced && pos == 8'h01 |-> line_tx_o == 8'h28) else $error("pattern byte two missing");
    AST_OVERHEAD_NO_TAKE: assert property (
        synced && pos < 8'h07 |-> !tx_take_o) else $error("client byte taken in overhead");
    AST_JUST_POS: assert property (
        synced && pos == 8'h07 |-> tx_take_o == $past(store_near_full_i, 8))
        else $error("justification byte use wrong");
    AST_JUST_NEG: assert property (
        synced && pos == 8'h08 |->
        tx_take_o == !($past(store_near_empty_i, 9) && !$past(store_near_full_i, 9)))
        else $error("first data position use wrong");
    AST_AIS_NEEDS_LOF: assert property (
        alarm_indication_signal_o |-> loss_of_frame_o) else $error("all-ones defect without lof");
    AST_DEFECT_ALL_ONES: assert property (
        dflt [*4] |-> rx_data_o == 8'hFF) else $error("data not replaced during defect");
    AST_NEAR_ES: assert property (
        near_errored_second_o == (near_blocks_o != 16'h0000 || near_defect_sec_o))
        else $error("errored second grading wrong");
    AST_NEAR_SES: assert property (
        near_severely_errored_second_o == (near_blocks_o >= 16'h001E || near_defect_sec_o))
        else $error("severely errored second grading wrong");
endmodule // ttm_checker

bind trail_termination_monitor ttm_checker #(.FRAME_LEN(FRAME_LEN)) i_ttm_checker (.*);

// *** tb/far_end_model.sv ***
/* far-end model: loops the line back as the remote end returns it, or sends all-ones
   or silence instead. assumes it shares the device clock. */
module far_end_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] tx_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       flip_i,
    output logic      [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // looped overhead carries remote error and defect bits home
    always @(posedge clk_i) begin
        case (mode_i)
            2'd1:    rx_o <= 8'hFF;
            2'd2:    rx_o <= 8'h00;
            default: rx_o <= tx_i ^ {7'h00, flip_i}; // single bit error on request
        endcase
    end
endmodule // far_end_model

// *** tb/trail_termination_monitor_tb.sv ***
/* testbench for trail_termination_monitor: line looped through the far-end model.
   assumes a 50 MHz clock and a shortened second of TICK cycles. */
module trail_termination_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer TICK = 200;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        nfull = 1'b0;
    logic        nempty = 1'b0;
    logic        conn = 1'b0;
    logic [7:0]  etrace = 8'h3C;
    logic [7:0]  elabel = 8'h15;
    logic [1:0]  mode = 2'h0;
    logic        flip = 1'b0;
    wire  [7:0]  ltx, lrx, rxd;
    wire  [15:0] nblk, fblk;
    wire         loss_of_frame, loss_of_pointer, alarm_indication_signal, tm, lm, remote_defect_indication, take, rxv, nds, nes, nses, nuas, fds, fes;
    integer      n_fail = 0;
    integer      n_tests = 0;
    integer      k, i, c;
    trail_termination_monitor #(.FRAME_LEN(16), .TIME_SWITCH(0), .TICK_CYCLES(TICK)) i_dut (
        .core_clk_i(clk), .rstn_i(rstn), .tx_data_i(8'h5A), .store_near_full_i(nfull),
        .store_near_empty_i(nempty), .conn_change_i(conn), .access_point_i(8'h3C),
        .payload_label_i(8'h15), .expected_trace_i(etrace), .expected_label_i(elabel),
        .line_rx_i(lrx), .line_tx_o(ltx), .tx_take_o(take), .rx_data_o(rxd), .rx_valid_o(rxv),
        .loss_of_frame_o(loss_of_frame), .loss_of_pointer_o(loss_of_pointer), .alarm_indication_signal_o(alarm_indication_signal),
        .trace_mismatch_o(tm), .label_mismatch_o(lm), .remote_defect_indication_o(remote_defect_indication),
        .near_blocks_o(nblk), .near_defect_sec_o(nds), .near_errored_second_o(nes),
        .near_severely_errored_second_o(nses), .near_unavailable_second_o(nuas),
        .far_blocks_o(fblk), .far_defect_sec_o(fds), .far_errored_second_o(fes),
        .far_severely_errored_second_o(), .far_unavailable_second_o());
    far_end_model i_far (.clk_i(clk), .tx_i(ltx), .mode_i(mode), .flip_i(flip), .rx_o(lrx));
    // clock and watchdog
    initial forever #10 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cycles(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_sync();
        for (k = 0; k < 600 && loss_of_frame !== 1'b0; k++) @(negedge clk);
        chk_bit(loss_of_frame, 1'b0);
    endtask
    task automatic end_test(input string name);
        $display("test %0s done", name);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // test sequence
    initial begin
        cycles(5);
        chk_bit(loss_of_frame, 1'b1);
        chk_val({8'h00, rxd}, 16'h00FF);
        rstn = 1'b1;
        wait_sync();
        cycles(40);
        chk_bit(tm, 1'b0);
        chk_bit(lm, 1'b0);
        chk_bit(remote_defect_indication, 1'b0);
        for (k = 0; k < 40 && rxv !== 1'b1; k++) @(negedge clk);
        chk_bit(rxv, 1'b1);
        chk_val({8'h00, rxd}, 16'h005A);
        end_test("loopback");
        for (i = 0; i < 3; i++) begin
            nfull = (i == 1);
            nempty = (i == 2);
            cycles(32);
            c = 0;
            repeat (16) begin
                @(negedge clk);
                c = c + take;
            end
            chk_val(c[15:0], (i == 1) ? 16'h0009 : (i == 2) ? 16'h0007 : 16'h0008);
        end
        nfull = 1'b0;
        nempty = 1'b0;
        conn = 1'b1;
        cycles(1);
        conn = 1'b0;
        cycles(40);
        chk_bit(loss_of_pointer, 1'b0);
        end_test("justification");
        for (i = 0; i < 2; i++) begin
            if (i == 0) etrace = 8'hC3;
            else elabel = 8'hEA;
            cycles(450);
            chk_bit((i == 0) ? tm : lm, 1'b1);
            chk_val({8'h00, rxd}, 16'h00FF);
            chk_bit(remote_defect_indication, 1'b1);
            chk_bit(fds, 1'b1);
            chk_bit(fes, 1'b1);
            etrace = 8'h3C;
            elabel = 8'h15;
            cycles(450);
            chk_bit(remote_defect_indication, 1'b0);
            chk_bit(fds, 1'b0);
        end
        end_test("mismatch");
        chk_val(nblk, 16'h0000);
        chk_bit(nes, 1'b0);
        for (k = 0; k < 40 && ltx !== 8'hF6; k++) @(negedge clk);
        cycles(10);
        flip = 1'b1;
        cycles(1);
        flip = 1'b0;
        for (k = 0; k < 600 && nblk === 16'h0000; k++) @(negedge clk);
        chk_val(nblk, 16'h0001);
        chk_bit(nes, 1'b1);
        for (k = 0; k < 600 && fblk === 16'h0000; k++) @(negedge clk);
        chk_val(fblk, 16'h0001);
        end_test("block errors");
        mode = 2'h1;
        cycles(2500);
        chk_bit(loss_of_frame, 1'b1);
        chk_bit(alarm_indication_signal, 1'b1);
        chk_val({8'h00, rxd}, 16'h00FF);
        chk_bit(nds, 1'b1);
        chk_bit(nuas, 1'b1);
        chk_bit(nses, 1'b1);
        mode = 2'h2;
        cycles(60);
        chk_bit(alarm_indication_signal, 1'b0);
        mode = 2'h0;
        wait_sync();
        end_test("all ones");
        results();
    end
endmodule // trail_termination_monitor_tb
